/* design/zero_store_pkg.sv */
package zero_store_pkg;
  // widths and sizes
  localparam int ZW         = 24;               // zero, reading and reply word width
  localparam int RANGES     = 8;                // ranges per function
  localparam int REPLY_MAX  = 15;               // error reply string capacity
  localparam int CAL_SLOTS  = 2 * RANGES;       // dc and ohms zero slots in cal memory
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // function, range, installed mask
  localparam logic [7:0] ADDR_READING = 8'h04;  // latest reading and overrange
  localparam logic [7:0] ADDR_CMD     = 8'h08;  // command opcode and argument
  localparam logic [7:0] ADDR_CHAR    = 8'h0C;  // reply string character
  localparam logic [7:0] ADDR_STATUS  = 8'h10;  // error buffer and flags
  localparam logic [7:0] ADDR_DATE    = 8'h14;  // stored date or identifier
  localparam logic [7:0] ADDR_REPLY   = 8'h40;  // 16 words of reply string
  // field positions
  localparam int CTRL_FUNC_LSB  = 0;            // 2 bits
  localparam int CTRL_RANGE_LSB = 2;            // 3 bits
  localparam int CTRL_INST_LSB  = 8;            // 3 bits, one per fitted function
  localparam int READ_OVR_BIT   = 24;           // overrange flag
  localparam int CMD_ARG_LSB    = 8;            // 20-bit argument
  // reset values
  localparam logic [10:0]   CTRL_RESET = 11'h700; // dc, lowest range, dc/ohms/ac
  localparam logic [7:0]    ERR_NONE   = 8'h00;
  localparam logic [19:0]   DATE_MAX   = 20'hF423F; // 999999
  // error codes, two bcd digits
  localparam logic [7:0] ERR_OVR_OFFSET = 8'h11;
  localparam logic [7:0] ERR_NO_HW      = 8'h19;
  localparam logic [7:0] ERR_CALMEM     = 8'h23;
  localparam logic [7:0] ERR_CONFIG     = 8'h24;
  localparam logic [7:0] ERR_CHECKSUM   = 8'h25;
  // characters
  localparam logic [7:0] CH_NUL  = 8'h00;
  localparam logic [7:0] CH_LF   = 8'h0A;
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOL  = 8'h24;
  localparam logic [7:0] CH_PCT  = 8'h25;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_QUES = 8'h3F;
  // timing: boot strap sampled this many cycles after release
  localparam logic [1:0] BOOT_WAIT = 2'h3;

  // functions
  localparam logic [1:0] FUNC_DC   = 2'h0;
  localparam logic [1:0] FUNC_OHMS = 2'h1;

  typedef enum logic [3:0] {
    trigger_cmd, store_dc_zero_cmd, store_resistance_zero_cmd, keep_gain_correction_cmd,
    keep_date_ident_cmd, set_error_reply_cmd, erase_cal_memory_cmd,
    store_scale_factor_cmd, recall_dc_zero_cmd, get_status_cmd, recall_cal_mode_cmd
  } cmd_e;

  typedef enum logic [1:0] {iface_bus, iface_serial, iface_parallel} iface_e;

  // one response toward the controller
  typedef struct packed {
    logic          valid;     // one-cycle pulse
    logic          is_error;  // send the error reply string instead of data
    logic [ZW-1:0] data;      // reading, recall value or status word
  } resp_s;
endpackage

/* design/zero_store_and_error_report.sv */
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Contract
// - cal on: store zero, selected range only
// - cal off: temp zero, range and above
// - temp zeros cleared at reset
// - date store: cal on, at most 999999
// - reply string keeps first 15 characters
// - nulls dropped, not counted
// - unprogrammed reply reads as "0"
// - immediate or terminator ends the string
// - dollar and hash immediate per interface
// - erase all, status reply, interrupt gives 25
// - dc recall: selected range or lowest range
// - recall permanent in cal, else temporary
// - pending error returns reply string
// - momentary once, latching every trigger
// - buffer keeps latest code only
// - status reports code then clears
// - valid reading clears buffer
// - latching codes re-raised each trigger
// - overrange offset store loads 11
// - missing hardware trigger loads 19
// - latching disable only local with cal
// - faulty cal memory 23, bad config 24
module zero_store_and_error_report
  import zero_store_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        cal_mode_pin,
  input  wire logic        remote_pin,
  input  wire logic        latch_off_pin,
  input  wire logic        calmem_ok_pin,
  input  wire logic        cfg_illegal_pin,
  input  wire logic [1:0]  iface_pin,
  input  wire logic [7:0]  hw_fault_code,
  output resp_s            resp,
  output logic             erase_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [6:0] pin_meta;        // first stage, read only by pin_sync
  logic [6:0] pin_sync;        // second stage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= {iface_pin, cfg_illegal_pin, calmem_ok_pin, latch_off_pin,
                   remote_pin, cal_mode_pin};
      pin_sync <= pin_meta;
    end
  end

  logic   cal_on;              // calibration switch
  logic   remote;              // remote operation
  logic   calmem_ok;           // calibration memory present and good
  logic   cfg_bad;             // illegal module configuration
  iface_e iface;               // installed interface
  assign cal_on    = pin_sync[0];
  assign remote    = pin_sync[1];
  assign calmem_ok = pin_sync[3];
  assign cfg_bad   = pin_sync[4];
  assign iface     = iface_e'(pin_sync[6:5]);

  ////////////////////////////////////////////////////////////////////////////
  // control and reading registers
  logic [10:0]   ctrl;         // function, range, installed mask
  logic [ZW:0]   reading;      // value plus overrange
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl    <= CTRL_RESET;
      reading <= '0;
    end else begin
      if (wr && addr == ADDR_CTRL) ctrl <= wdata[10:0];
      if (wr && addr == ADDR_READING) reading <= wdata[ZW:0];
    end
  end

  logic [1:0] func;
  logic [2:0] range_sel;
  logic       func_ok;         // hardware for this function fitted
  logic [3:0] inst_mask;       // installed per function, the last one never fitted
  assign func      = ctrl[CTRL_FUNC_LSB +: 2];
  assign range_sel = ctrl[CTRL_RANGE_LSB +: 3];
  // only three mask bits exist, so the fourth function reads as absent, never unknown
  assign inst_mask = {1'b0, ctrl[CTRL_INST_LSB +: 3]};
  assign func_ok   = inst_mask[func];

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  typedef enum logic [1:0] {st_idle, st_collect, st_erase} state_e;
  state_e state;
  logic   cmd_go;              // command write this cycle
  cmd_e   op;
  logic   ch_go;               // reply character arriving
  logic [7:0] ch;
  logic   ch_end;              // character ends the string
  assign cmd_go = wr && addr == ADDR_CMD;
  assign op     = cmd_e'(wdata[3:0]);
  assign ch     = wdata[7:0];
  assign ch_go  = wr && addr == ADDR_CHAR && state == st_collect;

  always_comb begin
    ch_end = (ch == CH_CR) || (ch == CH_LF) || (ch == CH_QUES) ||
             (ch == CH_STAR) || (ch == CH_PCT);
    if (ch == CH_DOL && iface == iface_serial) ch_end = 1'b1;
    if (ch == CH_HASH && iface != iface_bus) ch_end = 1'b1;
  end

  logic       ovr;             // stored reading is overrange
  logic       is_store_zero;   // either zero store command
  logic       latch_en;        // latching errors active
  logic [7:0] latch_code;      // latching cause seen at trigger
  logic       cfg_latch;       // configuration error still latched
  assign ovr           = reading[READ_OVR_BIT];
  assign is_store_zero = op == store_dc_zero_cmd || op == store_resistance_zero_cmd;
  assign latch_en      = remote || !cal_on || !pin_sync[2];

  always_comb begin
    latch_code = ERR_NONE;
    if (cfg_latch && latch_en) latch_code = ERR_CONFIG;
    if (hw_fault_code != ERR_NONE && latch_en) latch_code = hw_fault_code;
    if (!func_ok) latch_code = ERR_NO_HW;
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot check for the configuration strap
  logic [1:0] boot_cnt;        // cycles since release
  logic       boot_hit;        // strap sample moment
  assign boot_hit = boot_cnt == BOOT_WAIT - 2'h1;
  always_ff @(posedge mclk) begin
    if (!rst_b) boot_cnt <= 2'h0;
    else if (boot_cnt != BOOT_WAIT) boot_cnt <= boot_cnt + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // error events, later ones in the list win
  logic       err_ev;
  logic [7:0] err_code_ev;
  logic       erase_done;
  always_comb begin
    err_ev      = 1'b0;
    err_code_ev = ERR_NONE;
    if (boot_hit && cfg_bad) begin
      err_ev      = 1'b1;
      err_code_ev = ERR_CONFIG;
    end
    if (cmd_go && state != st_erase) begin
      if (op == trigger_cmd && latch_code != ERR_NONE) begin
        err_ev      = 1'b1;
        err_code_ev = latch_code;
      end
      if (!calmem_ok && (op == erase_cal_memory_cmd || op == keep_gain_correction_cmd ||
          (cal_on && (is_store_zero || op == keep_date_ident_cmd)))) begin
        err_ev      = 1'b1;
        err_code_ev = ERR_CALMEM;
      end
      if ((is_store_zero || op == store_scale_factor_cmd) && ovr) begin
        err_ev      = 1'b1;
        err_code_ev = ERR_OVR_OFFSET;
      end
    end
    if (cmd_go && state == st_erase && op != get_status_cmd) begin
      err_ev      = 1'b1;
      err_code_ev = ERR_CHECKSUM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero memories
  logic [ZW-1:0] perm_zero [CAL_SLOTS];  // non-volatile slots, not reset
  logic [ZW-1:0] dc_tmp    [RANGES];     // temporary dc zeros
  logic [ZW-1:0] ohm_tmp   [RANGES];     // temporary ohms zeros
  logic [19:0]   date_id;                // date or identifier
  logic [3:0]    erase_idx;              // slot being cleared
  logic          zero_ok;                // zero store accepted
  logic [3:0]    slot;                   // slot for the selected range
  assign zero_ok = cmd_go && state != st_erase && is_store_zero && !ovr;
  assign slot    = {op == store_resistance_zero_cmd, range_sel};

  // permanent zeros, date and erase walk
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      erase_idx <= 4'h0;
      date_id   <= 20'h00000;
    end else if (state == st_erase) begin
      perm_zero[erase_idx] <= '0;
      erase_idx            <= erase_idx + 4'h1;
      if (erase_done) date_id <= 20'h00000;
    end else begin
      erase_idx <= 4'h0;
      if (zero_ok && cal_on && calmem_ok) perm_zero[slot] <= reading[ZW-1:0];
      if (cmd_go && op == keep_date_ident_cmd && cal_on && calmem_ok &&
          wdata[CMD_ARG_LSB +: 20] <= DATE_MAX)
        date_id <= wdata[CMD_ARG_LSB +: 20];
    end
  end
  assign erase_done = state == st_erase && erase_idx == 4'(CAL_SLOTS - 1);

  // temporary zeros, one block per range
  genvar r;
  generate
    for (r = 0; r < RANGES; r++) begin : g_tmp
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          dc_tmp[r]  <= '0;
          ohm_tmp[r] <= '0;
        end else if (zero_ok && !cal_on && 3'(r) >= range_sel) begin
          if (op == store_dc_zero_cmd) dc_tmp[r] <= reading[ZW-1:0];
          else ohm_tmp[r] <= reading[ZW-1:0];
        end
      end
    end
  endgenerate

  logic [2:0]    rec_rng;
  logic [ZW-1:0] rec_val;
  assign rec_rng = (func == FUNC_DC) ? range_sel : 3'h0;
  assign rec_val = cal_on ? perm_zero[{1'b0, rec_rng}] : dc_tmp[rec_rng];

  ////////////////////////////////////////////////////////////////////////////
  // reply string collection
  logic [7:0] reply_mem [REPLY_MAX];     // programmed characters
  logic [3:0] reply_len;                 // count stored, 0 means default
  always_ff @(posedge mclk) begin
    if (!rst_b) reply_len <= 4'h0;
    else if (cmd_go && op == set_error_reply_cmd && state != st_erase) reply_len <= 4'h0;
    else if (ch_go && !ch_end && ch != CH_NUL && reply_len < 4'(REPLY_MAX)) begin
      reply_mem[reply_len] <= ch;
      reply_len            <= reply_len + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) state <= st_idle;
    else case (state)
      st_idle: begin
        if (cmd_go && op == set_error_reply_cmd) state <= st_collect;
        else if (cmd_go && op == erase_cal_memory_cmd && calmem_ok) state <= st_erase;
      end
      st_collect: begin
        if (ch_go && ch_end) state <= st_idle;
        else if (cmd_go && op == erase_cal_memory_cmd && calmem_ok) state <= st_erase;
        else if (cmd_go && op != set_error_reply_cmd) state <= st_idle;
      end
      st_erase: begin
        if (erase_done || (cmd_go && op != get_status_cmd)) state <= st_idle;
      end
      default: state <= st_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // error buffer, pending flag and responses
  logic [7:0]    err_code;     // two-digit buffer
  logic          err_pend;     // reply string owed
  logic          rec_pend;     // recall waits for trigger
  logic [ZW-1:0] rec_hold;     // value to send on trigger
  logic [ZW-1:0] status_word;
  assign status_word = {err_code, 1'b0, reply_len, cal_on, erase_busy,
                        err_pend, 6'h00, func};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      err_code  <= ERR_NONE;
      err_pend  <= 1'b0;
      rec_pend  <= 1'b0;
      rec_hold  <= '0;
      cfg_latch <= 1'b0;
      resp      <= '0;
    end else begin
      resp.valid <= 1'b0;
      if (boot_hit && cfg_bad) cfg_latch <= 1'b1;
      if (erase_done) begin
        resp     <= '{valid: 1'b1, is_error: 1'b0, data: status_word};
        err_code <= ERR_NONE;
      end
      if (cmd_go && state != st_erase) begin
        case (op)
          trigger_cmd: begin
            if (latch_code != ERR_NONE || err_pend || ovr) begin
              resp     <= '{valid: 1'b1, is_error: 1'b1, data: '0};
              err_pend <= 1'b0;
            end else begin
              resp     <= '{valid: 1'b1, is_error: 1'b0,
                            data: rec_pend ? rec_hold : reading[ZW-1:0]};
              rec_pend <= 1'b0;
              err_code <= ERR_NONE;
              // a strap hit in the same cycle wins over the clear
              if (func_ok && !(boot_hit && cfg_bad)) cfg_latch <= 1'b0;
            end
          end
          get_status_cmd: begin
            resp     <= '{valid: 1'b1, is_error: 1'b0, data: status_word};
            err_code <= ERR_NONE;
          end
          recall_dc_zero_cmd: begin
            rec_pend <= 1'b1;
            rec_hold <= rec_val;
          end
          recall_cal_mode_cmd: begin
            rec_pend <= 1'b1;
            rec_hold <= {{(ZW-1){1'b0}}, cal_on};
          end
          default: begin
          end
        endcase
      end
      // latest code wins, set over clear
      if (err_ev) begin
        err_code <= err_code_ev;
        if (!(cmd_go && op == trigger_cmd)) err_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) erase_busy <= 1'b0;
    else erase_busy <= (state == st_erase && !erase_done && !(cmd_go && op != get_status_cmd))
                    || (state != st_erase && cmd_go && op == erase_cal_memory_cmd && calmem_ok);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  logic [3:0] rix;
  assign rix = addr[5:2];
  always_ff @(posedge mclk) begin
    if (!rst_b) rdata <= 32'h00000000;
    else if (rd) begin
      rdata <= 32'h00000000;
      if (addr == ADDR_CTRL) rdata <= {21'h000000, ctrl};
      else if (addr == ADDR_READING) rdata <= {7'h00, reading};
      else if (addr == ADDR_STATUS) rdata <= {8'h00, status_word};
      else if (addr == ADDR_DATE) rdata <= {12'h000, date_id};
      else if (addr[7:6] == ADDR_REPLY[7:6] && addr[1:0] == 2'h0) begin
        if (reply_len == 4'h0 && rix == 4'h0) rdata <= {24'h000000, CH_ZERO};
        else if (rix < reply_len) rdata <= {24'h000000, reply_mem[rix]};
      end
    end
  end

endmodule

/* tb/zero_store_checker.sv */
`timescale 1ns/1ns
module zero_store_checker
  import zero_store_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [31:0] rdata,
  input  wire logic        calmem_ok_pin,
  input  wire resp_s       resp,
  input  wire logic        erase_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  wire       is_cmd = wr && (addr == ADDR_CMD);  // command register write
  wire [3:0] op     = wdata[3:0];                // opcode field
  // commands that start work; during erase the trigger and erase abort instead, status does not
  sequence s_trig;  is_cmd && op == 4'h0 && !erase_busy; endsequence
  sequence s_stat;  is_cmd && op == 4'h9 && !erase_busy && calmem_ok_pin; endsequence
  sequence s_erase; is_cmd && op == 4'h6 && !erase_busy && calmem_ok_pin; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  property p_trig_resp; s_trig |=> resp.valid; endproperty
  property p_stat_resp; s_stat |=> resp.valid; endproperty
  // a second status one idle cycle after the first must see an empty buffer
  property p_stat_twice;
    s_stat ##1 !wr ##1 s_stat |=> resp.data[23:16] == ERR_NONE;
  endproperty
  property p_erase_go; s_erase |=> erase_busy; endproperty
  // after 8 idle cycles, 8 more busy cycles, then one completion response
  property p_erase_done;
    s_erase ##1 (!wr)[*8] |=> erase_busy[*8] ##1 (resp.valid && !erase_busy);
  endproperty
  property p_erase_abort;
    erase_busy && is_cmd && op != 4'h9 |=> !erase_busy && !resp.valid;
  endproperty
  // every response has a cause one cycle earlier
  property p_resp_cause;
    resp.valid |-> $past(is_cmd && (op == 4'h0 || op == 4'h9) && !erase_busy)
                   || $past(erase_busy);
  endproperty
  property p_rd_hold; !$past(rd) |-> $stable(rdata); endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_trig_resp:   assert property (p_trig_resp)   else $error("no trigger response");
  a_stat_resp:   assert property (p_stat_resp)   else $error("no status response");
  a_stat_twice:  assert property (p_stat_twice)  else $error("buffer not cleared");
  a_erase_go:    assert property (p_erase_go)    else $error("erase not started");
  a_erase_done:  assert property (p_erase_done)  else $error("erase length wrong");
  a_erase_abort: assert property (p_erase_abort) else $error("erase not aborted");
  a_resp_cause:  assert property (p_resp_cause)  else $error("response uncaused");
  a_rd_hold:     assert property (p_rd_hold)     else $error("read data moved");
endmodule

/* tb/remote_ctl.sv */
`timescale 1ns/1ns
// controller side: drives the register port one request at a time
module remote_ctl
  import zero_store_pkg::*;
(
  input  wire logic        mclk,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata,
  input  wire logic        erase_busy
);
  // idle bus at time zero
  initial begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle strobe per request, one idle cycle between requests
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    wdata <= ~d;  // stale data must not be relied on
  endtask
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  task automatic wait_erase(output int n);
    n = 0;
    while (erase_busy !== 1'b0 && n < 40) begin
      @(negedge mclk);
      n++;
    end
  endtask
endmodule

/* tb/zero_store_and_error_report_bench.sv */
`timescale 1ns/1ns
module zero_store_and_error_report_bench;
  import zero_store_pkg::*;
  logic        mclk, rst_b, cal_mode_pin, remote_pin, latch_off_pin;
  logic        calmem_ok_pin, cfg_illegal_pin, wr, rd, erase_busy;
  logic [1:0]  iface_pin;      // 0 bus, 1 serial, 2 parallel
  logic [7:0]  hw_fault_code;  // latching fault from the analog side
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  resp_s       resp, rs;       // rs: response captured by go
  int          n_mismatch, total_checks, n, i;
  logic [1:0]  lens [3] = '{2'h3, 2'h0, 2'h1};  // kept length per interface
  ////////////////////////////////////////////////////////////////////////////////
  zero_store_and_error_report dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cal_mode_pin(cal_mode_pin), .remote_pin(remote_pin),
    .latch_off_pin(latch_off_pin), .calmem_ok_pin(calmem_ok_pin),
    .cfg_illegal_pin(cfg_illegal_pin), .iface_pin(iface_pin),
    .hw_fault_code(hw_fault_code), .resp(resp), .erase_busy(erase_busy));
  remote_ctl ctl (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .erase_busy(erase_busy));
  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // pins pass a two-stage sync, so give them three edges
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic do_reset;
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // command write, response captured in the cycle after
  task automatic go(input cmd_e op, input logic [19:0] arg);
    ctl.put(ADDR_CMD, {4'h0, arg, 4'h0, op});
    @(negedge mclk);
    rs = resp;
  endtask
  task automatic setctl(input logic [1:0] fn, input logic [2:0] rg);
    ctl.put(ADDR_CTRL, {21'h0, 3'h7, 3'h0, rg, fn});
  endtask
  task automatic reading(input logic [23:0] v, input logic ovr);
    ctl.put(ADDR_READING, {7'h0, ovr, v});
  endtask
  task automatic zchk(input logic [1:0] fn, input logic [2:0] rg, input logic [23:0] z);
    setctl(fn, rg);
    go(recall_dc_zero_cmd, 20'h0);
    go(trigger_cmd, 20'h0);
    chk(32'(rs.data), 32'(z));
  endtask
  task automatic err_is(input logic [7:0] code);
    go(get_status_cmd, 20'h0);
    chk(32'(rs.data[23:16]), 32'(code));
  endtask
  task automatic trig_err(input logic e);
    go(trigger_cmd, 20'h0);
    chk(32'(rs.is_error), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_b, cal_mode_pin, remote_pin, latch_off_pin, cfg_illegal_pin} = 5'b00100;
    calmem_ok_pin = 1'b1;
    iface_pin = 2'h0;
    hw_fault_code = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    settle();
    ctl.get(ADDR_REPLY, d);
    chk(d, 32'(CH_ZERO));
    // temporary zeros spread upward, lowest range stays apart
    reading(24'h000123, 1'b0);
    setctl(FUNC_DC, 3'h2);
    go(store_dc_zero_cmd, 20'h0);
    zchk(FUNC_DC, 3'h5, 24'h000123);
    zchk(FUNC_DC, 3'h1, 24'h000000);
    zchk(2'h2, 3'h4, 24'h000000);
    do_reset();
    zchk(FUNC_DC, 3'h5, 24'h000000);
    // calibration mode: erase then store per range
    @(posedge mclk);
    cal_mode_pin <= 1'b1;
    settle();
    go(erase_cal_memory_cmd, 20'h0);
    chk(32'(erase_busy), 32'h1);
    ctl.wait_erase(n);
    chk(32'(n), 32'd16);
    chk(32'(resp.valid), 32'h1);
    reading(24'h000456, 1'b0);
    setctl(FUNC_DC, 3'h3);
    go(store_dc_zero_cmd, 20'h0);
    zchk(FUNC_DC, 3'h3, 24'h000456);
    zchk(FUNC_DC, 3'h4, 24'h000000);
    reading(24'h000077, 1'b0);
    setctl(FUNC_DC, 3'h0);
    go(store_dc_zero_cmd, 20'h0);
    zchk(2'h2, 3'h6, 24'h000077);
    // date: limit, over limit, short value
    go(keep_date_ident_cmd, DATE_MAX);
    go(keep_date_ident_cmd, 20'hF4240);
    ctl.get(ADDR_DATE, d);
    chk(d, 32'(DATE_MAX));
    go(keep_date_ident_cmd, 20'h0002A);
    // erase cut short by a trigger
    go(erase_cal_memory_cmd, 20'h0);
    go(trigger_cmd, 20'h0);
    chk(32'(rs.valid), 32'h0);
    err_is(ERR_CHECKSUM);
    @(posedge mclk);
    cal_mode_pin <= 1'b0;
    settle();
    go(keep_date_ident_cmd, 20'h00005);
    ctl.get(ADDR_DATE, d);
    chk(d, 32'h0002A);
    zchk(FUNC_DC, 3'h3, 24'h000000);
    // reply string: null dropped, cap of fifteen
    go(set_error_reply_cmd, 20'h0);
    ctl.put(ADDR_CHAR, 32'h41);
    ctl.put(ADDR_CHAR, 32'(CH_NUL));
    repeat (16) ctl.put(ADDR_CHAR, 32'h42);
    ctl.put(ADDR_CHAR, 32'(CH_CR));
    ctl.get(ADDR_STATUS, d);
    chk(32'(d[14:11]), 32'd15);
    ctl.get(ADDR_REPLY + 8'h04, d);
    chk(d, 32'h42);
    // dollar and hash per interface
    for (i = 2; i >= 0; i--) begin
      @(posedge mclk);
      iface_pin <= 2'(i);
      settle();
      go(set_error_reply_cmd, 20'h0);
      ctl.put(ADDR_CHAR, 32'(CH_DOL));
      ctl.put(ADDR_CHAR, 32'(CH_HASH));
      ctl.put(ADDR_CHAR, 32'h58);
      ctl.put(ADDR_CHAR, 32'(CH_CR));
      ctl.get(ADDR_STATUS, d);
      chk(32'(d[14:11]), 32'(lens[i]));
    end
    // momentary errors
    reading(24'h000100, 1'b1);
    go(store_dc_zero_cmd, 20'h0);
    err_is(ERR_OVR_OFFSET);
    reading(24'h000100, 1'b0);
    go(trigger_cmd, 20'h0);
    go(trigger_cmd, 20'h0);
    chk(32'(rs.data), 32'h100);
    err_is(ERR_NONE);
    reading(24'h000100, 1'b1);
    go(store_dc_zero_cmd, 20'h0);
    reading(24'h000100, 1'b0);
    trig_err(1'b1);
    trig_err(1'b0);
    // latching error over a momentary one
    reading(24'h000100, 1'b1);
    go(store_dc_zero_cmd, 20'h0);
    reading(24'h000100, 1'b0);
    setctl(2'h3, 3'h0);
    trig_err(1'b1);
    err_is(ERR_NO_HW);
    err_is(ERR_NONE);
    trig_err(1'b1);
    err_is(ERR_NO_HW);
    setctl(FUNC_DC, 3'h0);
    @(posedge mclk);
    hw_fault_code <= 8'h12;
    trig_err(1'b1);
    err_is(8'h12);
    @(posedge mclk);
    hw_fault_code <= 8'h00;
    // configuration strap and memory fault
    cfg_illegal_pin <= 1'b1;
    settle();
    do_reset();
    err_is(ERR_CONFIG);
    @(posedge mclk);
    cfg_illegal_pin <= 1'b0;
    calmem_ok_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    go(erase_cal_memory_cmd, 20'h0);
    chk(32'(erase_busy), 32'h0);
    err_is(ERR_CALMEM);
    end_of_test();
  end
endmodule

bind zero_store_and_error_report zero_store_checker u_chk (.mclk(mclk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .calmem_ok_pin(calmem_ok_pin), .resp(resp), .erase_busy(erase_busy));
